// ---- pkg/acg_map.svh ----
// Holds the timing, field and reset constants of the converter control block.
// Assumes it is included by bare name from the correction and control rtl files.
`ifndef ACG_MAP_SVH
`define ACG_MAP_SVH

// ==================================================================
// Timing
`define ACG_CLK_MHZ 200
`define ACG_SELF_CAL_MS 200
`define ACG_SYS_CAL_MS 100
// Milliseconds times one thousand give microseconds, and times MHz give cycles.
`define ACG_SELF_CAL_CYC (`ACG_SELF_CAL_MS * 1000 * `ACG_CLK_MHZ)
`define ACG_SYS_CAL_CYC (`ACG_SYS_CAL_MS * 1000 * `ACG_CLK_MHZ)

// ==================================================================
// Command byte fields
`define ACG_CMD_START 7
`define ACG_CMD_MODE 6
`define ACG_CMD_CAL_HI 5
`define ACG_CMD_CAL_LO 4
`define ACG_CMD_PWRDN 3
`define ACG_CMD_RATE_HI 2
`define ACG_CMD_RATE_LO 0

// ==================================================================
// Calibration select codes
`define ACG_CAL_NONE 2'h0
`define ACG_CAL_SELF 2'h1
`define ACG_CAL_SYS_ZERO 2'h2
`define ACG_CAL_SYS_FULL 2'h3

// ==================================================================
// Reset values and scaling
`define ACG_COEFF_RST 24'h000000
`define ACG_DIS_RST 1'h1
`define ACG_UNCAL_NUM 8'h99
`define ACG_UNCAL_SHIFT 8
`define ACG_GAIN_ONE 24'h800000
`define ACG_CONT_MULT 4
`define ACG_CONT_SETTLE 3'h3

`endif

// ---- pkg/acg_pkg.sv ----
// Types shared by the converter control block.
// Assumes nothing beyond the map header.
package acg_pkg;
  typedef enum logic [3:0] {
    ACG_IDLE = 4'h1,
    ACG_SELF = 4'h2,
    ACG_SYSZ = 4'h4,
    ACG_SYSF = 4'h8
  } acg_cal_state_t;
endpackage : acg_pkg

// ---- rtl/acg_gpio.sv ----
// Four general-purpose pins steered by direction and level bits.
// Assumes pin inputs arrive asynchronously and are synchronised here.
`timescale 1ns/100ps
module acg_gpio #(
  parameter int N = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Control
  input wire logic [N-1:0] pin_direction,
  input wire logic [N-1:0] pin_level,
  // Pins
  input wire logic [N-1:0] gpio_in,
  output logic [N-1:0] gpio_out,
  output logic [N-1:0] gpio_oe,
  output logic [N-1:0] gpio_rd
);
  logic [N-1:0] meta_ff;
  logic [N-1:0] sync_ff;

  // ================================================================
  // Per-pin drive and input capture
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_pin
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          gpio_out[i] <= 1'b0;
          gpio_oe[i] <= 1'b0;
          meta_ff[i] <= 1'b0;
          sync_ff[i] <= 1'b0;
        end else begin
          gpio_oe[i] <= pin_direction[i];
          gpio_out[i] <= pin_direction[i] & pin_level[i];
          meta_ff[i] <= gpio_in[i];
          sync_ff[i] <= meta_ff[i];
        end
      end
      // An output pin reads back its own drive; an input reads the pad.
      assign gpio_rd[i] = gpio_oe[i] ? gpio_out[i] : sync_ff[i];
    end
  endgenerate

  pin_drive_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ##1 (gpio_out == ($past(pin_direction) & $past(pin_level))))
    else $error("gpio drive does not follow level bits");
endmodule : acg_gpio

// ---- rtl/acg_corr.sv ----
// Digital correction of raw results by offset and gain coefficients.
// Assumes coefficients are two's complement offsets and gains with 1.0 at 0x800000.
`timescale 1ns/100ps
`include "acg_map.svh"
module acg_corr #(
  parameter int W = 24
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Raw result
  input wire logic [W-1:0] raw_data,
  input wire logic raw_valid,
  // Coefficients and enables
  input wire logic [W-1:0] self_off,
  input wire logic [W-1:0] self_gain,
  input wire logic [W-1:0] sys_off,
  input wire logic [W-1:0] sys_gain,
  input wire logic [3:0] dis_bits,
  // Result
  output logic [W-1:0] out_data,
  output logic out_valid
);
  logic signed [W+1:0] x;
  logic signed [2*W+3:0] prod;
  logic signed [W+1:0] y;

  // Gain factors are clamped to 0.5 .. 1.5; offsets to a quarter of full scale.
  function automatic logic signed [W+1:0] clamp_gain(input logic [W-1:0] g);
    logic signed [W+1:0] v;
    v = signed'({2'b00, g});
    if (v < signed'({2'b00, 24'h400000})) v = signed'({2'b00, 24'h400000});
    if (v > signed'({2'b00, 24'hC00000})) v = signed'({2'b00, 24'hC00000});
    return v;
  endfunction : clamp_gain

  function automatic logic signed [W+1:0] clamp_off(input logic [W-1:0] o);
    logic signed [W+1:0] v;
    v = signed'({{2{o[W-1]}}, o}) >>> 1;
    if (v > signed'({4'h0, 22'h200000})) v = signed'({4'h0, 22'h200000});
    if (v < -signed'({4'h0, 22'h200000})) v = -signed'({4'h0, 22'h200000});
    return v;
  endfunction : clamp_off

  // ================================================================
  // Correction path
  always_comb begin
    x = signed'({{2{raw_data[W-1]}}, raw_data});
    if (dis_bits == 4'hF) begin
      // Uncalibrated output is held to about sixty percent of full range.
      prod = x * signed'({2'b00, `ACG_UNCAL_NUM});
      x = (W+2)'(prod >>> `ACG_UNCAL_SHIFT);
    end else begin
      prod = '0;
    end
    if (!dis_bits[0]) x = x - clamp_off(self_off);
    if (!dis_bits[1]) begin
      prod = x * clamp_gain(self_gain);
      x = (W+2)'(prod >>> (W-1));
    end
    if (!dis_bits[2]) x = x - clamp_off(sys_off);
    if (!dis_bits[3]) begin
      prod = x * clamp_gain(sys_gain);
      x = (W+2)'(prod >>> (W-1));
    end
    y = x;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      out_data <= '0;
      out_valid <= 1'b0;
    end else begin
      out_valid <= raw_valid;
      if (raw_valid) out_data <= y[W-1:0];
    end
  end
endmodule : acg_corr

// ---- rtl/acg_ctrl.sv ----
// Converter control: clock select, buffers, calibration sequencer, rate, GPIO.
// Assumes command bytes arrive as one-cycle strobes from the serial port logic.
// How it works
// - line_freq_select 0 picks fast oscillator, 1 picks slow oscillator.
// - Mode bit 0 means convert/calibrate/power-down; 1 means register access.
// - Reference and signal buffers each follow their own enable bit.
// - Either supply's power-on reset restores all defaults.
// - All four coefficient registers reset to zero.
// - Four coefficient disable bits reset to one.
// - Uncalibrated output is scaled to about sixty percent full scale.
// - Host coefficients give gain 0.5 to 1.5, offset up to quarter reference.
// - Select 01 runs 200 ms self-calibration, loads self offset and gain.
// - Select 10 runs 100 ms zero-scale calibration, loads system offset.
// - Select 11 runs 100 ms full-scale calibration, loads system gain.
// - Single-cycle bit picks mode; rate field sets output rate.
// - Single-cycle results settle with no latency, up to 120 or 100 sps.
// - Continuous rate is four times single-cycle rate.
// - Continuous mode gives three unsettled results after an input step.
// - Decimation is fourth-order sinc with corner at 24 percent of rate.
// - Four pins follow direction and level bits.
// - One level bit set with all outputs drives only that pin high.
`timescale 1ns/100ps
`include "acg_map.svh"
module acg_ctrl #(
  parameter int W = 24,
  parameter int NPIN = 4,
  parameter longint SELF_CAL_CYC = `ACG_SELF_CAL_CYC,
  parameter longint SYS_CAL_CYC = `ACG_SYS_CAL_CYC
) (
  // Clock and resets
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic por_dig,
  input wire logic por_ana,
  // Command byte strobe
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_valid,
  // Configuration writes
  input wire logic cfg_we,
  input wire logic line_freq_select,
  input wire logic ext_clk_select,
  input wire logic ref_buffer_enable,
  input wire logic signal_buffer_enable,
  input wire logic single_cycle_select,
  input wire logic [3:0] dis_wdata,
  input wire logic [NPIN-1:0] pin_direction,
  input wire logic [NPIN-1:0] pin_level,
  // Coefficient writes
  input wire logic [1:0] coeff_sel,
  input wire logic [W-1:0] coeff_wdata,
  input wire logic coeff_we,
  // Modulator side
  input wire logic [W-1:0] raw_data,
  input wire logic raw_valid,
  input wire logic input_step,
  input wire logic [W-1:0] cal_result,
  input wire logic [W-1:0] cal_result_gain,
  // Status and control outputs
  output logic osc_fast_en,
  output logic osc_slow_en,
  output logic ref_buf_on,
  output logic sig_buf_on,
  output logic busy,
  output logic reg_access,
  output logic reg_write,
  output logic [3:0] reg_sel,
  output logic pwr_down,
  output logic conv_cont,
  output logic [2:0] rate_code,
  output logic [2:0] rate_mult,
  output logic conv_start,
  output logic settled,
  output logic [3:0] dis_bits,
  output logic [W-1:0] self_off_ff,
  output logic [W-1:0] self_gain_ff,
  output logic [W-1:0] sys_off_ff,
  output logic [W-1:0] sys_gain_ff,
  output logic [W-1:0] out_data,
  output logic out_valid,
  // Pins
  input wire logic [NPIN-1:0] gpio_in,
  output logic [NPIN-1:0] gpio_out,
  output logic [NPIN-1:0] gpio_oe,
  output logic [NPIN-1:0] gpio_rd
);
  acg_pkg::acg_cal_state_t st_ff;
  acg_pkg::acg_cal_state_t nxt_st;
  logic [39:0] cnt_ff;
  logic rst_any;
  logic line_freq_select_ff;
  logic extclk_ff;
  logic scyc_ff;
  logic [NPIN-1:0] dir_ff;
  logic [NPIN-1:0] lvl_ff;
  logic [2:0] unsettled_ff;
  logic [1:0] cal_sel;
  logic cmd_conv;

  // Supply resets act together with the system reset.
  assign rst_any = sys_rst | por_dig | por_ana;
  assign cal_sel = cmd_byte[`ACG_CMD_CAL_HI:`ACG_CMD_CAL_LO];
  assign cmd_conv = cmd_valid & cmd_byte[`ACG_CMD_START] & ~cmd_byte[`ACG_CMD_MODE];

  // ================================================================
  // Configuration bits
  always_ff @(posedge clk_sys) begin
    if (rst_any) begin
      line_freq_select_ff <= 1'b0;
      extclk_ff <= 1'b0;
      ref_buf_on <= 1'b0;
      sig_buf_on <= 1'b0;
      scyc_ff <= 1'b1;
      dir_ff <= '0;
      lvl_ff <= '0;
      dis_bits <= {4{`ACG_DIS_RST}};
    end else if (cfg_we) begin
      line_freq_select_ff <= line_freq_select;
      extclk_ff <= ext_clk_select;
      ref_buf_on <= ref_buffer_enable;
      sig_buf_on <= signal_buffer_enable;
      scyc_ff <= single_cycle_select;
      dir_ff <= pin_direction;
      lvl_ff <= pin_level;
      dis_bits <= dis_wdata;
    end
  end

  // With the external clock selected both internal oscillators stop.
  assign osc_fast_en = ~extclk_ff & ~line_freq_select_ff;
  assign osc_slow_en = ~extclk_ff & line_freq_select_ff;

  // ================================================================
  // Command decode
  always_ff @(posedge clk_sys) begin
    if (rst_any) begin
      reg_access <= 1'b0;
      reg_write <= 1'b0;
      reg_sel <= '0;
      pwr_down <= 1'b0;
      rate_code <= '0;
      conv_start <= 1'b0;
    end else begin
      reg_access <= cmd_valid & cmd_byte[`ACG_CMD_START] & cmd_byte[`ACG_CMD_MODE];
      conv_start <= 1'b0;
      if (reg_access == 1'b0 && cmd_valid && cmd_byte[`ACG_CMD_MODE]) begin
        reg_write <= ~cmd_byte[0];
        reg_sel <= cmd_byte[4:1];
      end
      // A command arriving mid-calibration is dropped, not queued.
      if (cmd_conv && !busy) begin
        rate_code <= cmd_byte[`ACG_CMD_RATE_HI:`ACG_CMD_RATE_LO];
        pwr_down <= cmd_byte[`ACG_CMD_PWRDN];
        conv_start <= (cal_sel == `ACG_CAL_NONE) & ~cmd_byte[`ACG_CMD_PWRDN];
      end
    end
  end

  // Continuous mode runs four output words per single-cycle period.
  assign conv_cont = ~scyc_ff;
  assign rate_mult = scyc_ff ? 3'h1 : 3'(`ACG_CONT_MULT);

  // ================================================================
  // Settling: single-cycle results are settled at once; continuous mode
  // counts three results after a step through the sinc4 pipeline.
  always_ff @(posedge clk_sys) begin
    if (rst_any) begin
      unsettled_ff <= '0;
    end else if (input_step && !scyc_ff) begin
      unsettled_ff <= `ACG_CONT_SETTLE;
    end else if (out_valid && unsettled_ff != 3'h0) begin
      unsettled_ff <= unsettled_ff - 3'h1;
    end
  end
  assign settled = scyc_ff | (unsettled_ff == 3'h0);

  // ================================================================
  // Calibration sequencer
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      acg_pkg::ACG_IDLE: begin
        if (cmd_conv) begin
          case (cal_sel)
            `ACG_CAL_SELF: nxt_st = acg_pkg::ACG_SELF;
            `ACG_CAL_SYS_ZERO: nxt_st = acg_pkg::ACG_SYSZ;
            `ACG_CAL_SYS_FULL: nxt_st = acg_pkg::ACG_SYSF;
            default: nxt_st = acg_pkg::ACG_IDLE;
          endcase
        end
      end
      acg_pkg::ACG_SELF: if (cnt_ff == 40'(SELF_CAL_CYC - 1)) nxt_st = acg_pkg::ACG_IDLE;
      acg_pkg::ACG_SYSZ: if (cnt_ff == 40'(SYS_CAL_CYC - 1)) nxt_st = acg_pkg::ACG_IDLE;
      acg_pkg::ACG_SYSF: if (cnt_ff == 40'(SYS_CAL_CYC - 1)) nxt_st = acg_pkg::ACG_IDLE;
      default: nxt_st = acg_pkg::ACG_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst_any) begin
      st_ff <= acg_pkg::ACG_IDLE;
      cnt_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= (st_ff == acg_pkg::ACG_IDLE || nxt_st == acg_pkg::ACG_IDLE) ? '0
                                                                              : cnt_ff + 40'h1;
    end
  end
  assign busy = (st_ff != acg_pkg::ACG_IDLE);

  // ================================================================
  // Coefficient registers; a finishing calibration wins over a host write.
  always_ff @(posedge clk_sys) begin
    if (rst_any) begin
      self_off_ff <= `ACG_COEFF_RST;
      self_gain_ff <= `ACG_COEFF_RST;
      sys_off_ff <= `ACG_COEFF_RST;
      sys_gain_ff <= `ACG_COEFF_RST;
    end else if (busy && nxt_st == acg_pkg::ACG_IDLE) begin
      case (st_ff)
        acg_pkg::ACG_SELF: begin
          self_off_ff <= cal_result;
          self_gain_ff <= cal_result_gain;
        end
        acg_pkg::ACG_SYSZ: sys_off_ff <= cal_result;
        acg_pkg::ACG_SYSF: sys_gain_ff <= cal_result_gain;
        default: self_off_ff <= self_off_ff;
      endcase
    end else if (coeff_we) begin
      case (coeff_sel)
        2'h0: self_off_ff <= coeff_wdata;
        2'h1: self_gain_ff <= coeff_wdata;
        2'h2: sys_off_ff <= coeff_wdata;
        default: sys_gain_ff <= coeff_wdata;
      endcase
    end
  end

  acg_corr #(.W(W)) u_corr (
    .clk_sys(clk_sys),
    .sys_rst(rst_any),
    .raw_data(raw_data),
    .raw_valid(raw_valid),
    .self_off(self_off_ff),
    .self_gain(self_gain_ff),
    .sys_off(sys_off_ff),
    .sys_gain(sys_gain_ff),
    .dis_bits(dis_bits),
    .out_data(out_data),
    .out_valid(out_valid)
  );

  acg_gpio #(.N(NPIN)) u_gpio (
    .clk_sys(clk_sys),
    .sys_rst(rst_any),
    .pin_direction(dir_ff),
    .pin_level(lvl_ff),
    .gpio_in(gpio_in),
    .gpio_out(gpio_out),
    .gpio_oe(gpio_oe),
    .gpio_rd(gpio_rd)
  );

  // ================================================================
  // Checks
  osc_select_a: assert property (@(posedge clk_sys) disable iff (rst_any)
    !(osc_fast_en && osc_slow_en) && (osc_slow_en == (line_freq_select_ff & ~extclk_ff)))
    else $error("oscillator select wrong");
  por_default_a: assert property (@(posedge clk_sys)
    $past(por_ana | por_dig) |-> (dis_bits == 4'hF) && !busy)
    else $error("defaults not restored after supply reset");
  self_start_a: assert property (@(posedge clk_sys) disable iff (rst_any)
    (!busy && cmd_conv && cal_sel == `ACG_CAL_SELF) |=> st_ff == acg_pkg::ACG_SELF)
    else $error("self calibration did not start");
  zero_start_a: assert property (@(posedge clk_sys) disable iff (rst_any)
    (!busy && cmd_conv && cal_sel == `ACG_CAL_SYS_ZERO) |=> busy ##1 busy)
    else $error("zero scale calibration did not start");
  full_start_a: assert property (@(posedge clk_sys) disable iff (rst_any)
    (!busy && cmd_conv && cal_sel == `ACG_CAL_SYS_FULL) |=> st_ff == acg_pkg::ACG_SYSF)
    else $error("full scale calibration did not start");
  busy_block_a: assert property (@(posedge clk_sys) disable iff (rst_any)
    busy |=> !conv_start)
    else $error("conversion started during calibration");
  rate_mult_a: assert property (@(posedge clk_sys) disable iff (rst_any)
    conv_cont |-> rate_mult == 3'h4)
    else $error("continuous rate multiplier wrong");
  settle_cnt_a: assert property (@(posedge clk_sys) disable iff (rst_any)
    (input_step && conv_cont) |=> !settled)
    else $error("step not marked unsettled");
  buf_follow_a: assert property (@(posedge clk_sys) disable iff (rst_any)
    cfg_we |=> (ref_buf_on == $past(ref_buffer_enable)))
    else $error("reference buffer does not follow write");
  cal_seen_c: cover property (@(posedge clk_sys) disable iff (rst_any)
    busy ##1 !busy);
  conv_seen_c: cover property (@(posedge clk_sys) disable iff (rst_any) conv_start);
  reg_seen_c: cover property (@(posedge clk_sys) disable iff (rst_any) reg_access);
endmodule : acg_ctrl

// ---- sim/acg_host_model.sv ----
// Host controller model that hands command bytes to the converter control block.
// Assumes the block takes a byte on the rising edge where the strobe is high.
`timescale 1ns/100ps
module acg_host_model (
  // Clock
  input wire logic clk_sys,
  // Command byte lines
  output logic [7:0] cmd_byte,
  output logic cmd_valid
);
  initial begin
    cmd_byte = 8'h00;
    cmd_valid = 1'b0;
  end

  // ==================================================================
  // Command transfer
  // The strobe stands for exactly one edge. The byte lines then carry the
  // inverse, because a real serial front end gives no hold after its strobe.
  task send_cmd(input logic [7:0] b);
    @(posedge clk_sys);
    cmd_byte <= b;
    cmd_valid <= 1'b1;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    cmd_byte <= ~b;
  endtask : send_cmd
endmodule : acg_host_model

// ---- sim/adc_calibration_rate_gpio_ctrl_tb.sv ----
// Self-checking bench for the converter control block with a host model.
// Assumes short calibration counts so that every sequence runs to the end.
`timescale 1ns/100ps
module adc_calibration_rate_gpio_ctrl_tb;
  localparam int SELF_N = 20;
  localparam int SYS_N = 10;
  logic clk_sys = 1'b0, sys_rst = 1'b1, por_dig = 1'b0, por_ana = 1'b0;
  logic [7:0] cmd_byte;
  logic cmd_valid, cfg_we = 1'b0, line_freq_select = 1'b0, ext_clk_select = 1'b0;
  logic ref_buffer_enable = 1'b0, signal_buffer_enable = 1'b0, single_cycle_select = 1'b1;
  logic [3:0] dis_wdata = 4'hF, pin_direction = 4'h0, pin_level = 4'h0, gpio_in = 4'h0;
  logic [1:0] coeff_sel = 2'h0;
  logic [23:0] coeff_wdata = 24'h000000, raw_data = 24'h000000;
  logic [23:0] cal_result = 24'h00007E, cal_result_gain = 24'hBFD345;
  logic coeff_we = 1'b0, raw_valid = 1'b0, input_step = 1'b0;
  logic osc_fast_en, osc_slow_en, ref_buf_on, sig_buf_on, busy, reg_access, reg_write;
  logic pwr_down, conv_cont, conv_start, settled, out_valid;
  logic [3:0] reg_sel, dis_bits, gpio_out, gpio_oe, gpio_rd;
  logic [2:0] rate_code, rate_mult;
  logic [23:0] self_off_ff, self_gain_ff, sys_off_ff, sys_gain_ff, out_data;
  int num_errors = 0;
  int checked = 0;

  always #2.5 clk_sys = ~clk_sys;

  acg_host_model host (.clk_sys, .cmd_byte, .cmd_valid);

  acg_ctrl #(.SELF_CAL_CYC(SELF_N), .SYS_CAL_CYC(SYS_N)) uut (
    .clk_sys, .sys_rst, .por_dig, .por_ana, .cmd_byte, .cmd_valid, .cfg_we,
    .line_freq_select, .ext_clk_select, .ref_buffer_enable, .signal_buffer_enable,
    .single_cycle_select, .dis_wdata, .pin_direction, .pin_level, .coeff_sel,
    .coeff_wdata, .coeff_we, .raw_data, .raw_valid, .input_step, .cal_result,
    .cal_result_gain, .osc_fast_en, .osc_slow_en, .ref_buf_on, .sig_buf_on, .busy,
    .reg_access, .reg_write, .reg_sel, .pwr_down, .conv_cont, .rate_code, .rate_mult,
    .conv_start, .settled, .dis_bits, .self_off_ff, .self_gain_ff, .sys_off_ff,
    .sys_gain_ff, .out_data, .out_valid, .gpio_in, .gpio_out, .gpio_oe, .gpio_rd
  );

  // ==================================================================
  // Shared tasks
  task print_verdict;
    if (num_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Control bits are {external clock, line select, ref buffer, signal buffer, single cycle}.
  task cfg(input logic [4:0] ctl, input logic [3:0] dis, input logic [3:0] dir,
           input logic [3:0] lvl);
    @(posedge clk_sys);
    {ext_clk_select, line_freq_select, ref_buffer_enable} <= ctl[4:2];
    {signal_buffer_enable, single_cycle_select} <= ctl[1:0];
    dis_wdata <= dis;
    pin_direction <= dir;
    pin_level <= lvl;
    cfg_we <= 1'b1;
    @(posedge clk_sys);
    cfg_we <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask : cfg

  task pulse_raw(input logic [23:0] d);
    @(posedge clk_sys);
    raw_data <= d;
    raw_valid <= 1'b1;
    @(posedge clk_sys);
    raw_valid <= 1'b0;
    #1;
  endtask : pulse_raw

  // ==================================================================
  // Scenarios
  task test_reset;
    check("disable bits", dis_bits, 4'hF);
    check("coefficients", {self_off_ff | self_gain_ff | sys_off_ff | sys_gain_ff}, 0);
    check("oscillator", {osc_fast_en, osc_slow_en}, 2'h2);
    check("buffers", {ref_buf_on, sig_buf_on}, 2'h0);
    check("pins driven", gpio_oe, 4'h0);
    check("busy", busy, 1'h0);
  endtask : test_reset

  task test_config;
    cfg(5'b01010, 4'hF, 4'h0, 4'h0);
    check("oscillator", {osc_fast_en, osc_slow_en}, 2'h1);
    check("buffers", {ref_buf_on, sig_buf_on}, 2'h1);
    check("continuous", {conv_cont, rate_mult}, 4'hC);
    cfg(5'b11010, 4'hF, 4'h0, 4'h0);
    check("external clock", {osc_fast_en, osc_slow_en}, 2'h0);
    cfg(5'b00101, 4'hF, 4'h0, 4'h0);
    check("oscillator", {osc_fast_en, osc_slow_en}, 2'h2);
    check("buffers", {ref_buf_on, sig_buf_on}, 2'h2);
    check("single cycle", {conv_cont, rate_mult}, 4'h1);
    pulse_raw(24'h100000);
    check("uncalibrated data", {out_valid, out_data}, 25'h1099000);
  endtask : test_config

  task test_commands;
    host.send_cmd(8'h8D);
    #1;
    check("conversion", {conv_start, reg_access, pwr_down, rate_code}, 6'h0D);
    host.send_cmd(8'h80);
    #1;
    check("conversion", {conv_start, pwr_down, rate_code}, 5'h10);
    host.send_cmd(8'hC6);
    #1;
    check("register write", {reg_access, conv_start, reg_write, reg_sel}, 7'h53);
    host.send_cmd(8'hDF);
    #1;
    check("register read", {reg_access, reg_write, reg_sel}, 6'h2F);
  endtask : test_commands

  // A command sent mid-calibration must be dropped and must not stretch it.
  task test_cal(input logic [1:0] code, input int n_exp, input bit refuse);
    int n;
    host.send_cmd({2'b10, code, 4'h0});
    #1;
    check("busy at start", busy, 1'h1);
    n = 1;
    if (refuse) begin
      host.send_cmd(8'h87);
      #1;
      check("refused start", conv_start, 1'h0);
      n = 3;
    end
    while (busy === 1'b1 && n < 200) begin
      @(posedge clk_sys);
      #1;
      if (busy === 1'b1) n++;
    end
    check("busy cycles", n, n_exp);
    if (n >= 200) print_verdict();
    if (code == 2'h1) check("self offset", self_off_ff, cal_result);
    if (code == 2'h1) check("self gain", self_gain_ff, cal_result_gain);
    if (code == 2'h2) check("system offset", sys_off_ff, cal_result);
    if (code == 2'h3) check("system gain", sys_gain_ff, cal_result_gain);
  endtask : test_cal

  task test_coeff_por;
    @(posedge clk_sys);
    coeff_sel <= 2'h3;
    coeff_wdata <= 24'hC00000;
    coeff_we <= 1'b1;
    @(posedge clk_sys);
    coeff_we <= 1'b0;
    #1;
    check("host gain", sys_gain_ff, 24'hC00000);
    cfg(5'b00101, 4'h7, 4'h0, 4'h0);
    pulse_raw(24'h100000);
    check("gain correction", out_data, 24'h180000);
    @(posedge clk_sys);
    por_ana <= 1'b1;
    @(posedge clk_sys);
    por_ana <= 1'b0;
    #1;
    check("analog reset", {dis_bits, sys_gain_ff | self_off_ff}, 28'hF000000);
    cfg(5'b00101, 4'h0, 4'h0, 4'h0);
    @(posedge clk_sys);
    por_dig <= 1'b1;
    @(posedge clk_sys);
    por_dig <= 1'b0;
    #1;
    check("digital reset", {dis_bits, osc_fast_en}, 5'h1F);
  endtask : test_coeff_por

  // The host opens every switch before it closes the next one.
  task test_gpio;
    int i;
    cfg(5'b00101, 4'hF, 4'hF, 4'h1);
    check("pins one", {gpio_oe, gpio_out}, 8'hF1);
    cfg(5'b00101, 4'hF, 4'hF, 4'h0);
    check("pins open", {gpio_oe, gpio_out}, 8'hF0);
    cfg(5'b00101, 4'hF, 4'hF, 4'h4);
    check("pins three", {gpio_oe, gpio_out}, 8'hF4);
    cfg(5'b00101, 4'hF, 4'h0, 4'h0);
    gpio_in <= 4'hA;
    for (i = 0; i < 8 && gpio_rd !== 4'hA; i++) begin
      @(posedge clk_sys);
      #1;
    end
    check("pins read", {gpio_oe, gpio_rd}, 8'h0A);
  endtask : test_gpio

  task test_settle;
    int k;
    cfg(5'b00100, 4'hF, 4'h0, 4'h0);
    @(posedge clk_sys);
    input_step <= 1'b1;
    @(posedge clk_sys);
    input_step <= 1'b0;
    #1;
    check("after step", settled, 1'h0);
    for (k = 1; k <= 3; k++) begin
      pulse_raw(24'h000100);
      // The count drops on the edge after the one that registers the corrected word.
      @(posedge clk_sys);
      #1;
      check("settling", settled, (k == 3));
    end
  endtask : test_settle

  // ==================================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    test_reset();
    test_config();
    test_commands();
    cfg(5'b00101, 4'hC, 4'h0, 4'h0);
    test_cal(2'h1, SELF_N, 1'b1);
    cal_result <= 24'hFFEE1D;
    cal_result_gain <= 24'h81CB5B;
    test_cal(2'h2, SYS_N, 1'b0);
    test_cal(2'h3, SYS_N, 1'b0);
    test_coeff_por();
    test_gpio();
    test_settle();
    print_verdict();
  end
endmodule : adc_calibration_rate_gpio_ctrl_tb
